// ---- hw/mcp_port.sv ----
// Command decoder, read answer, calibration ramp and output driver of the sensor.
`timescale 1ns/1ps
module mcp_port #(
	parameter int RAMP_CYC = mcp_pkg::RAMP_MAX_CYC,
	parameter int STAT_CYC = mcp_pkg::STATUS_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic cal_in,
	output logic cal_o,
	output logic cal_oe,
	input wire logic light_above_ref,
	input wire logic [1:0] gain_bits,
	output logic out_o,
	output logic out_oe,
	output logic [9:0] led_drive_count,
	output logic led_pulse,
	output logic [3:0] thresh_code
);
	import mcp_pkg::*;

	mcp_state_t state;
	logic cal_prev;
	logic rise;
	logic fall;
	logic [3:0] rx_cnt;
	logic [11:0] rx_tmr;
	logic [11:0] rx_period;
	logic [11:0] rx_sh;
	logic rx_new;
	logic sync_ok6;
	logic wr_go;
	logic [5:0] cfg;
	logic [5:0] wr_data;
	logic verify;
	logic err_flag;
	logic [12:0] cal_bank;
	logic [21:0] tmr;
	logic [9:0] tx_cnt;
	logic tx_phase;
	logic [5:0] tx_idx;
	logic tx_last;
	logic [RESP_BITS-1:0] resp;
	logic [7:0] pulse_cnt;
	logic tick;
	logic [1:0] hits;
	logic [9:0] ramp_cnt;
	logic ramp_ok;
	logic ramp_fail;
	logic cal_ok;
	logic det_lvl;

	function automatic logic [11:0] quarter(input logic [11:0] p);
		quarter = {2'h0, p[11:2]};
	endfunction

	assign rise = cal_in & ~cal_prev;
	assign fall = ~cal_in & cal_prev;
	assign sync_ok6 = rx_new && rx_cnt == 4'(CMD_BITS) && rx_sh[5:2] == SYNC_CODE;
	assign wr_go = rx_new && rx_cnt == 4'(WR_BITS) && rx_sh[11:6] == {SYNC_CODE, CMD_WRITE};

	always_ff @(posedge core_clk) begin
		cal_prev <= resetn ? cal_in : 1'b0;
	end

	// Bit period is learnt from the two leading ones, so any rate in range decodes.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_cnt <= 4'h0;
			rx_tmr <= 12'h000;
			rx_period <= 12'h000;
			rx_sh <= 12'h000;
			rx_new <= 1'b0;
		end else if (state != ST_RX) begin
			rx_cnt <= 4'h0;
			rx_tmr <= 12'h000;
			rx_new <= 1'b0;
		end else begin
			rx_new <= 1'b0;
			if (rx_tmr != 12'hFFF) begin
				rx_tmr <= rx_tmr + 12'h001;
			end
			if (rx_cnt == 4'h0) begin
				if (rise) begin // RULE1
					rx_cnt <= 4'h1;
					rx_tmr <= 12'h000;
					rx_sh <= 12'h001;
				end
			end else if (rx_cnt == 4'h1) begin
				if (rise) begin // RULE6
					rx_period <= rx_tmr;
					rx_cnt <= 4'h2;
					rx_tmr <= 12'h000;
					rx_sh <= {rx_sh[10:0], 1'b1};
					rx_new <= 1'b1;
				end else if (rx_tmr >= 12'(RX_MAX_PERIOD_CYC)) begin
					rx_cnt <= 4'h0;
				end
			end else if ((rise || fall) && rx_tmr >= rx_period - quarter(rx_period)) begin
				// Edges before three quarters of a period are bit-boundary edges.
				rx_sh <= {rx_sh[10:0], rise}; // RULE7 RULE5
				rx_cnt <= rx_cnt + 4'h1;
				rx_tmr <= 12'h000;
				rx_new <= 1'b1;
			end else if (rx_tmr > rx_period + quarter(rx_period)) begin
				rx_cnt <= 4'h0; // RULE23
			end
			if (rx_new && rx_cnt == 4'(CMD_BITS) && rx_sh[5:0] != {SYNC_CODE, CMD_WRITE}) begin
				rx_cnt <= 4'h0; // RULE3 RULE23
			end
			if (rx_new && rx_cnt == 4'(WR_BITS)) begin
				rx_cnt <= 4'h0; // RULE4
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= ST_RX;
			tmr <= 22'h00_0000;
		end else begin
			tmr <= tmr + 22'h00_0001;
			unique case (state)
				ST_RX: begin
					if (sync_ok6 && rx_sh[1:0] == CMD_READ) begin // RULE2 RULE21
						state <= ST_TX;
						tmr <= 22'h00_0000;
					end else if (sync_ok6 && rx_sh[1:0] == CMD_CAL) begin // RULE2
						state <= ST_RAMP;
						tmr <= 22'h00_0000;
					end
				end
				ST_TX: begin
					if (tx_last) begin
						state <= ST_RX;
					end
				end
				ST_RAMP: begin
					if (ramp_ok || ramp_fail) begin // RULE14
						state <= ST_STATUS;
						tmr <= 22'h00_0000;
					end
				end
				ST_STATUS: begin
					if (tmr == 22'(STAT_CYC - 1)) begin // RULE14
						state <= ST_RX;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cfg <= CFG_RESET; // RULE20
			wr_data <= CFG_RESET;
			verify <= 1'b0;
			err_flag <= 1'b0;
		end else begin
			verify <= wr_go;
			if (wr_go) begin
				cfg <= rx_sh[5:0]; // RULE4 RULE12
				wr_data <= rx_sh[5:0];
			end
			if (verify) begin
				err_flag <= cfg != wr_data; // RULE22
			end
		end
	end

	// Read answer, first bit sent is index 0.
	always_comb begin
		resp = '0;
		resp[RESP_ERR_POS] = err_flag; // RULE9
		resp[RESP_CA_POS] = cal_bank[CALB_OK_POS];
		resp[RESP_GAIN_POS +: 2] = gain_bits;
		resp[RESP_LED_POS +: 10] = cal_bank[CALB_CNT_LSB +: 10];
		resp[RESP_REF_POS +: 4] = cfg[3:0]; // RULE10
		resp[RESP_DS_POS] = cfg[CFG_DS_POS];
		resp[RESP_OP_POS] = cfg[CFG_OP_POS];
	end

	assign tx_last = tx_phase && tx_cnt == 10'(TX_HALF_CYC - 1) && tx_idx == 6'(RESP_BITS - 1);

	always_ff @(posedge core_clk) begin
		if (!resetn || state != ST_TX) begin
			tx_cnt <= 10'h000;
			tx_phase <= 1'b0;
			tx_idx <= 6'h00;
		end else if (tx_cnt == 10'(TX_HALF_CYC - 1)) begin // RULE8
			tx_cnt <= 10'h000;
			tx_phase <= ~tx_phase;
			if (tx_phase) begin
				tx_idx <= tx_idx + 6'h01;
			end
		end else begin
			tx_cnt <= tx_cnt + 10'h001;
		end
	end

	assign tick = state == ST_RAMP && pulse_cnt == 8'(LED_PERIOD_CYC - 1);
	assign ramp_ok = tick && light_above_ref && hits == 2'h1;
	assign ramp_fail = (tick && !light_above_ref && ramp_cnt == LED_CNT_MAX)
		|| (state == ST_RAMP && tmr == 22'(RAMP_CYC - 1));

	always_ff @(posedge core_clk) begin
		if (!resetn || state != ST_RAMP) begin
			pulse_cnt <= 8'h00;
			hits <= 2'h0;
			ramp_cnt <= 10'h000;
		end else begin
			pulse_cnt <= tick ? 8'h00 : pulse_cnt + 8'h01;
			if (tick && light_above_ref) begin
				hits <= hits + 2'h1; // RULE13
			end else if (tick) begin
				hits <= 2'h0;
				if (ramp_cnt != LED_CNT_MAX) begin
					ramp_cnt <= ramp_cnt + 10'h001; // RULE13
				end
			end
		end
	end

	// A failed ramp still records its last drive count, flagged as unsuccessful.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cal_bank <= CALB_RESET;
			cal_ok <= 1'b0;
		end else if (ramp_ok || ramp_fail) begin
			cal_bank <= {ramp_cnt, 2'h0, ramp_ok}; // RULE11 RULE13
			cal_ok <= ramp_ok;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cal_o <= 1'b0;
			cal_oe <= 1'b0;
		end else begin
			cal_oe <= state == ST_RAMP || state == ST_STATUS;
			cal_o <= state == ST_RAMP || (state == ST_STATUS && !cal_ok); // RULE15 RULE16 RULE17
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			led_drive_count <= 10'h000;
			led_pulse <= 1'b0;
			thresh_code <= CFG_RESET[3:0];
		end else begin
			led_drive_count <= state == ST_RAMP ? ramp_cnt : cal_bank[CALB_CNT_LSB +: 10];
			led_pulse <= tick;
			thresh_code <= cfg[3:0]; // RULE19
		end
	end

	assign det_lvl = cfg[CFG_OP_POS] ? ~light_above_ref : light_above_ref;

	// Outside a read answer, open drain mode releases the pin for a high level instead of driving it.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			out_o <= 1'b1;
			out_oe <= 1'b0;
		end else if (state == ST_TX) begin
			out_oe <= 1'b1;
			out_o <= resp[tx_idx] ~^ tx_phase; // RULE7 RULE8 RULE21
		end else begin
			out_o <= det_lvl; // RULE20
			out_oe <= cfg[CFG_DS_POS] | ~det_lvl;
		end
	end

	property p_ramp_high;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_RAMP |=> cal_oe && cal_o;
	endproperty
	a_ramp_high: assert property (p_ramp_high) else $error("pin not high in ramp"); // RULE15

	property p_status_ok;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_STATUS && cal_ok |=> cal_oe && !cal_o;
	endproperty
	a_status_ok: assert property (p_status_ok) else $error("success not low"); // RULE16

	property p_status_fail;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_STATUS && !cal_ok |=> cal_oe && cal_o;
	endproperty
	a_status_fail: assert property (p_status_fail) else $error("failure not high"); // RULE17

	property p_verify;
		@(posedge core_clk) disable iff (!resetn)
		wr_go |=> ##1 err_flag == $past(cfg != wr_data);
	endproperty
	a_verify: assert property (p_verify) else $error("mismatch not flagged"); // RULE22

	property p_tx_code;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_TX |=> out_oe && out_o == ($past(resp[tx_idx]) ~^ $past(tx_phase));
	endproperty
	a_tx_code: assert property (p_tx_code) else $error("bad answer coding"); // RULE7

	property p_resp_zero;
		@(posedge core_clk) disable iff (!resetn)
		!resp[0] && resp[RESP_BITS-1:30] == 7'h00;
	endproperty
	a_resp_zero: assert property (p_resp_zero) else $error("fixed answer bits"); // RULE10

	property p_thresh;
		@(posedge core_clk) disable iff (!resetn)
		wr_go ##1 1'b1 |=> thresh_code == $past(rx_sh[3:0], 2);
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold not applied"); // RULE19

	property p_nop;
		@(posedge core_clk) disable iff (!resetn)
		sync_ok6 && rx_sh[1:0] == CMD_NOP |=> state == ST_RX && rx_cnt == 4'h0 && $stable(cfg);
	endproperty
	a_nop: assert property (p_nop) else $error("reserved command acted"); // RULE2

	property p_ramp_len;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_RAMP |-> tmr < 22'(RAMP_CYC);
	endproperty
	a_ramp_len: assert property (p_ramp_len) else $error("ramp too long"); // RULE14

	property p_step;
		@(posedge core_clk) disable iff (!resetn)
		tick && !light_above_ref && ramp_cnt != LED_CNT_MAX && !ramp_fail
			|=> ramp_cnt == $past(ramp_cnt) + 10'h001;
	endproperty
	a_step: assert property (p_step) else $error("drive not stepped"); // RULE13
endmodule

// ---- hw/mcp_pkg.sv ----
// Constants, field layout and state codes for the single-wire command port.
// Behaviour
// [RULE1] A command frame opens with sync bits 1100; ones give clock, zeros confirm.
// [RULE2] Command bits: 00 does nothing, 01 reads, 10 writes config, 11 calibrates.
// [RULE3] Read and calibrate frames are six bits, with no data bits.
// [RULE4] Write frames are twelve bits; the last six are stored config data.
// [RULE5] Host sends config data bit 5 first, down to bit 0.
// [RULE6] Incoming bits decode correctly from 50 to 200 kb/s, nominal 100.
// [RULE7] Manchester: zero falls at mid-bit, one rises; data XOR bit clock.
// [RULE8] Read answer leaves on the output pin, Manchester at 100 kb/s, even halves.
// [RULE9] Answer is 37 bits: zero, error, reserved, cal flag, gain, drive count.
// [RULE10] Then threshold code, drain select, polarity; bits 31 to 37 are zero. The code zeroes answer bits 30 to 36.
// [RULE11] Calibration bank: drive count in 12:3, two unused, success flag in 0.
// [RULE12] Config bank: polarity bit 5, drain select bit 4, threshold 3:0.
// [RULE13] Calibration raises drive each pulse, stops after two hits, stores count.
// [RULE14] Ramp lasts at most 17 ms, then a 13 ms status interval.
// [RULE15] Calibrate pin is driven high from accepted request until ramp end.
// [RULE16] After a successful ramp the pin is driven low for the status interval.
// [RULE17] After a failed ramp the pin stays high for the status interval.
// [RULE18] Host writes config, calibrates, then writes a new threshold code.
// [RULE19] A written threshold code reaches the comparator at once.
// [RULE20] Default output is push-pull and inverted: low while an object is seen.
// [RULE21] Commands arrive on the calibrate pin; answers leave on the output pin.
// [RULE22] After a write the bank is read back; any mismatch sets the error flag.
// [RULE23] Bad sync or short frames are dropped without touching stored settings.
package mcp_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int TX_RATE_BPS = 100_000;
	localparam int TX_HALF_CYC = CLK_HZ / (2 * TX_RATE_BPS);
	localparam int RX_MIN_BPS = 50_000;
	localparam int RX_MAX_PERIOD_CYC = CLK_HZ / RX_MIN_BPS;
	localparam int LED_PERIOD_NS = 2000;
	localparam int LED_PERIOD_CYC = LED_PERIOD_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int RAMP_MAX_MS = 17;
	localparam int STATUS_MS = 13;
	localparam int RAMP_MAX_CYC = RAMP_MAX_MS * (CLK_HZ / 1000);
	localparam int STATUS_CYC = STATUS_MS * (CLK_HZ / 1000);
	localparam int RESP_BITS = 37;
	localparam int CMD_BITS = 6;
	localparam int WR_BITS = 12;
	localparam logic [3:0] SYNC_CODE = 4'hC;
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_CAL = 2'h3;
	localparam int CFG_OP_POS = 5;
	localparam int CFG_DS_POS = 4;
	localparam logic [5:0] CFG_RESET = 6'h38;
	localparam int CALB_OK_POS = 0;
	localparam int CALB_CNT_LSB = 3;
	localparam logic [12:0] CALB_RESET = 13'h0001;
	localparam logic [9:0] LED_CNT_MAX = 10'h3FF;
	localparam int RESP_ERR_POS = 1;
	localparam int RESP_CA_POS = 11;
	localparam int RESP_GAIN_POS = 12;
	localparam int RESP_LED_POS = 14;
	localparam int RESP_REF_POS = 24;
	localparam int RESP_DS_POS = 28;
	localparam int RESP_OP_POS = 29;
	typedef enum logic [1:0] {
		ST_RX = 2'b00,
		ST_TX = 2'b01,
		ST_RAMP = 2'b10,
		ST_STATUS = 2'b11
	} mcp_state_t;
endpackage

// ---- sim/mcp_host.sv ----
// Host model: sends Manchester commands on the calibrate wire and samples the output pin.
`timescale 1ns/1ps
module mcp_host (
	input wire logic core_clk,
	input wire logic pin,
	output logic drv,
	output logic en
);
	import mcp_pkg::*;
	initial begin
		drv = 1'b0;
		en = 1'b0;
	end
	// Bits go MSB first from bit 11; the last bit is released soon after its mid edge.
	task automatic send(input logic [11:0] bits, input int n, input int h);
		for (int i = 0; i < n; i++) begin
			en = 1'b1;
			drv = ~bits[11-i];
			repeat (h) @(negedge core_clk);
			drv = bits[11-i];
			repeat ((i == n - 1) ? 4 : h) @(negedge core_clk);
		end
		// The wire has a pull-down, so a released line reads low.
		en = 1'b0;
		drv = 1'b0;
	endtask
	// Each half is sampled near its middle, which leaves room for a few cycles of skew.
	task automatic answer(output logic [36:0] a, output logic [36:0] b);
		repeat (309) @(negedge core_clk);
		for (int k = 0; k < RESP_BITS; k++) begin
			a[k] = pin;
			repeat (TX_HALF_CYC) @(negedge core_clk);
			b[k] = pin;
			repeat (TX_HALF_CYC) @(negedge core_clk);
		end
	endtask
endmodule

// ---- sim/manchester_cmd_calibration_port_tb.sv ----
// Self-checking bench for the single-wire command port.
`timescale 1ns/1ps
module manchester_cmd_calibration_port_tb;
	logic core_clk, resetn, cal_in, cal_o, cal_oe, light_above_ref, out_o, out_oe;
	logic h_drv, h_en, out_pin;
	logic [1:0] gain_bits;
	logic [9:0] led_drive_count;
	logic led_pulse;
	logic [3:0] thresh_code;
	logic [5:0] cfg;
	logic [31:0] seed;
	logic [36:0] a, b;
	int bad_count, samples_checked, n, pulses, base;
	assign cal_in = cal_oe ? cal_o : (h_en ? h_drv : 1'b0);
	assign out_pin = out_oe ? out_o : 1'b1;
	mcp_port #(.RAMP_CYC(3000), .STAT_CYC(500)) u_dut (.core_clk, .resetn, .cal_in, .cal_o,
		.cal_oe, .light_above_ref, .gain_bits, .out_o, .out_oe, .led_drive_count,
		.led_pulse, .thresh_code);
	mcp_host u_host (.core_clk, .pin(out_pin), .drv(h_drv), .en(h_en));
	always #4 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic step();
		seed = lfsr(seed);
	endtask
	function automatic logic [1:0] det(input logic [5:0] c, input logic l);
		logic o;
		o = c[5] ? ~l : l;
		return {c[4] | ~o, o};
	endfunction
	function automatic logic [36:0] resp(input logic [5:0] c, input logic [1:0] g);
		resp = '0;
		resp[11] = 1'b1;
		resp[13:12] = g;
		resp[27:24] = c[3:0];
		resp[28] = c[4];
		resp[29] = c[5];
	endfunction
	task automatic check(input logic [36:0] got, input logic [36:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic gap(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	initial begin
		gap(104000);
		bad_count++;
		wrap_up();
	end
	// Pulses are counted at the falling edge, where the registered strobe has settled.
	always @(negedge core_clk) begin
		if (led_pulse === 1'b1) begin
			pulses++;
		end
	end
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		seed = 32'h8f14_24d4;
		step();
		gain_bits = seed[1:0];
		light_above_ref = seed[2];
		gap(10);
		resetn = 1'b1;
		gap(3);
		check({cal_oe, thresh_code}, 5'h08);
		check({out_oe, out_o}, det(6'h38, light_above_ref));
		// A slow host writes the output type and a calibration threshold first.
		step();
		cfg = {2'b11, seed[5:2]};
		u_host.send({4'hC, 2'h2, cfg}, 12, 700);
		gap(8);
		check(thresh_code, cfg[3:0]);
		u_host.send({4'hE, 2'h2, 6'h00}, 6, 313);
		gap(50);
		u_host.send({4'hC, 2'h0, 6'h00}, 6, 313);
		gap(50);
		u_host.send({4'hC, 2'h2, ~cfg}, 9, 313);
		gap(1000);
		check({cal_oe, thresh_code}, {1'b0, cfg[3:0]});
		u_host.send({4'hC, 2'h1, 6'h00}, 6, 313);
		u_host.answer(a, b);
		check(a, ~resp(cfg, gain_bits));
		check(b, resp(cfg, gain_bits));
		gap(500);
		check({out_oe, out_o}, det(cfg, light_above_ref));
		light_above_ref = 1'b1;
		base = pulses;
		u_host.send({4'hC, 2'h3, 6'h00}, 6, 313);
		gap(100);
		check({cal_oe, cal_o}, 2'b11);
		n = 0;
		while (cal_o !== 1'b0 && n < 3500) begin
			gap(1);
			n++;
		end
		check(cal_o, 1'b0);
		gap(480);
		check({cal_oe, cal_o}, 2'b10);
		check(pulses - base, 2);
		check(led_drive_count, 10'h000);
		gap(40);
		check(cal_oe, 1'b0);
		gap(200);
		// With no light the ramp runs out, so the wire must stay high to the end.
		light_above_ref = 1'b0;
		base = pulses;
		u_host.send({4'hC, 2'h3, 6'h00}, 6, 313);
		for (int i = 0; i < 34; i++) begin
			gap(100);
			check({cal_oe, cal_o}, 2'b11);
			if (i < 29) begin
				check(led_drive_count, pulses - base);
			end
		end
		// The time limit falls on the last pulse, so that pulse adds no step.
		check(pulses - base, 3000 / mcp_pkg::LED_PERIOD_CYC);
		check(led_drive_count, 3000 / mcp_pkg::LED_PERIOD_CYC - 1);
		gap(300);
		check(cal_oe, 1'b0);
		step();
		cfg = seed[5:0];
		u_host.send({4'hC, 2'h2, cfg}, 12, 313);
		gap(4);
		check(thresh_code, cfg[3:0]);
		for (int i = 0; i < 6; i++) begin
			step();
			light_above_ref = seed[0];
			gap(3);
			check({out_oe, out_o}, det(cfg, light_above_ref));
		end
		wrap_up();
	end
endmodule
